// >>> dv/pmd_core_model.sv
// Core-side access and register driver for the region decoder
`timescale 1ns/1ps
`default_nettype none
module pmd_core_model (
   input  wire logic              i_clk,
   input  wire logic [63:0]       i_rdata,
   input  wire pmd_pkg::pmd_rsp_s i_rsp,
   output logic                   o_we,
   output logic [2:0]             o_sel,
   output logic [63:0]            o_wdata,
   output pmd_pkg::pmd_req_s      o_req
);
   initial begin
      o_we = 1'b0;
      o_sel = 3'h0;
      o_wdata = 64'h0;
      o_req = '0;
   end

   // Held one full cycle, so the write is taken at the next edge
   task automatic wr(input logic [2:0] s, input logic [63:0] d);
      @(posedge i_clk) #1;
      o_we = 1'b1;
      o_sel = s;
      o_wdata = d;
      @(posedge i_clk) #1;
      o_we = 1'b0;
      o_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [2:0] s, output logic [63:0] d);
      @(posedge i_clk) #1;
      o_sel = s;
      @(posedge i_clk) #1;
      d = i_rdata;
   endtask : rd

   // Address flipped after release so stale values never match
   task automatic acc(input logic w, input logic [51:0] a,
                      output pmd_pkg::pmd_rsp_s r);
      @(posedge i_clk) #1;
      o_req = '{1'b1, w, a};
      @(posedge i_clk) #1;
      r = i_rsp;
      o_req.valid = 1'b0;
      o_req.addr = ~a;
   endtask : acc
endmodule : pmd_core_model
`default_nettype wire

// >>> dv/pmd_decoder_test.sv
// Self-checking bench for the region decoder
`timescale 1ns/1ps
`default_nettype none
module pmd_decoder_test;
   logic                I_CLK;
   logic                I_NRST;
   logic                we;
   logic [2:0]          sel;
   logic [63:0]         wdata;
   logic [63:0]         rdata;
   pmd_pkg::pmd_req_s   req;
   pmd_pkg::pmd_rsp_s   rsp;
   logic                mts;
   logic                ce;
   int                  n_fail;
   int                  n_checks;
   logic [63:0]         v;

   pmd_decoder #(.N_PAIRS(2)) pmd_decoder_i (
      .I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(ce), .I_REG_WE(we),
      .I_REG_SEL(sel), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
      .I_REQ(req), .O_RSP(rsp), .O_MEM_TYPE_SEL(mts));

   pmd_core_model pmd_core_model_i (
      .i_clk(I_CLK), .i_rdata(rdata), .i_rsp(rsp), .o_we(we),
      .o_sel(sel), .o_wdata(wdata), .o_req(req));

   initial begin
      I_CLK = 1'b0;
      forever #2 I_CLK = ~I_CLK;
   end

   task automatic chk64(input logic [63:0] g, input logic [63:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %0t: read %h want %h", $time, g, e);
      end
   endtask : chk64

   task automatic chk_rsp(input pmd_pkg::pmd_rsp_s g, input logic m, input logic h);
      n_checks++;
      if (g !== {1'b1, m, h} || mts !== h) begin
         n_fail++;
         $display("Error %0t: rsp %b want 1%b%b", $time, g, m, h);
      end
   endtask : chk_rsp

   task automatic go(input logic w, input logic [51:0] a, input logic m, input logic h);
      pmd_pkg::pmd_rsp_s r;
      pmd_core_model_i.acc(w, a, r);
      chk_rsp(r, m, h);
   endtask : go

   task automatic t_low;
      // Junk outside bits 51..23 must not move the boundary
      pmd_core_model_i.wr(pmd_pkg::SEL_TOM_LOW, 64'hFFF0_0000_807F_FFFF);
      pmd_core_model_i.wr(pmd_pkg::SEL_SYSTEM_CONFIG_REG, 64'h10_0000);
      pmd_core_model_i.rd(pmd_pkg::SEL_TOM_LOW, v);
      chk64(v, 64'hFFF0_0000_807F_FFFF);
      go(1'b0, 52'h0, 1'b0, 1'b0);
      go(1'b1, 52'h7FFF_FFFF, 1'b0, 1'b0);
      go(1'b0, 52'h8000_0000, 1'b1, 1'b0);
      go(1'b0, 52'hFFFF_FFFF, 1'b1, 1'b0);
      go(1'b0, 52'h1_0000_0000, 1'b1, 1'b0);
      $display("test low done");
   endtask : t_low

   task automatic t_high;
      pmd_core_model_i.wr(pmd_pkg::SEL_TOM_HIGH, 64'h2_0000_0000);
      pmd_core_model_i.wr(pmd_pkg::SEL_SYSTEM_CONFIG_REG, 64'h30_0000);
      go(1'b0, 52'h1_0000_0000, 1'b0, 1'b0);
      go(1'b1, 52'h1_FFFF_FFFF, 1'b0, 1'b0);
      go(1'b0, 52'h2_0000_0000, 1'b1, 1'b0);
      go(1'b1, 52'hF_FFFF_FFFF_FFFF, 1'b1, 1'b0);
      pmd_core_model_i.wr(pmd_pkg::SEL_SYSTEM_CONFIG_REG, 64'h20_0000);
      go(1'b0, 52'h0, 1'b1, 1'b0);
      go(1'b0, 52'h1_0000_0000, 1'b0, 1'b0);
      $display("test high done");
   endtask : t_high

   task automatic t_io;
      pmd_core_model_i.wr(pmd_pkg::SEL_IO_BASE0, 64'h1008);
      pmd_core_model_i.wr(pmd_pkg::SEL_IO_MASK0, 64'hF_FFFF_FFFF_F000);
      go(1'b1, 52'h1234, 1'b1, 1'b0);
      pmd_core_model_i.wr(pmd_pkg::SEL_IO_MASK0, 64'hF_FFFF_FFFF_F800);
      go(1'b1, 52'h1234, 1'b0, 1'b1);
      go(1'b0, 52'h1FFF, 1'b1, 1'b1);
      go(1'b1, 52'h2000, 1'b1, 1'b0);
      // Second pair kept apart from the first
      pmd_core_model_i.wr(pmd_pkg::SEL_IO_BASE1, 64'h10_0010);
      pmd_core_model_i.wr(pmd_pkg::SEL_IO_MASK1, 64'hF_FFFF_FFF0_0800);
      go(1'b0, 52'h1F_F000, 1'b0, 1'b1);
      go(1'b1, 52'h10_0000, 1'b1, 1'b1);
      go(1'b0, 52'h20_0000, 1'b1, 1'b0);
      $display("test io done");
   endtask : t_io

   task automatic t_freeze;
      // A write offered while the clock enable is low must be lost
      @(posedge I_CLK) #1;
      ce = 1'b0;
      pmd_core_model_i.wr(pmd_pkg::SEL_SYSTEM_CONFIG_REG, 64'h30_0000);
      ce = 1'b1;
      go(1'b0, 52'h0, 1'b1, 1'b0);
      // Unused select: write dropped, read gives zero
      pmd_core_model_i.wr(3'h7, 64'hFFFF_FFFF_FFFF_FFFF);
      pmd_core_model_i.rd(pmd_pkg::SEL_SYSTEM_CONFIG_REG, v);
      chk64(v, 64'h0000_0000_0020_0000);
      pmd_core_model_i.rd(3'h7, v);
      chk64(v, 64'h0000_0000_0000_0000);
      $display("test freeze done");
   endtask : t_freeze

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   initial begin
      n_fail = 0;
      n_checks = 0;
      I_NRST = 1'b0;
      ce = 1'b1;
      repeat (3) @(posedge I_CLK);
      #1 I_NRST = 1'b1;
      go(1'b0, 52'h0, 1'b1, 1'b0);
      t_low();
      t_high();
      t_io();
      t_freeze();
      give_verdict();
   end

   initial begin
      #20000;
      n_fail++;
      give_verdict();
   end
endmodule : pmd_decoder_test
`default_nettype wire

// >>> logic/pmd_decoder.sv
// Physical address decoder: system memory versus memory-mapped I/O
`timescale 1ns/1ps
`default_nettype none
module pmd_decoder #(
   parameter int N_PAIRS = 2
) (
   input  wire logic              I_CLK,
   input  wire logic              I_NRST,
   input  wire logic              I_CE,
   input  wire logic              I_REG_WE,
   input  wire logic [2:0]        I_REG_SEL,
   input  wire logic [63:0]       I_REG_WDATA,
   output logic      [63:0]       O_REG_RDATA,
   input  wire pmd_pkg::pmd_req_s I_REQ,
   output pmd_pkg::pmd_rsp_s      O_RSP,
   output logic                   O_MEM_TYPE_SEL
);
   // Register map and read mux are written for exactly two pairs
   if (N_PAIRS != 2) begin : g_bad_pairs
      $error("pmd_decoder serves exactly two range pairs");
   end

   typedef struct packed {
      logic [63:0]                       system_config_reg;
      logic [63:0]                       tom_low;
      logic [63:0]                       tom_high;
      pmd_pkg::pmd_pair_s [N_PAIRS-1:0]  pair;
      pmd_pkg::pmd_rsp_s                 rsp;
      logic [63:0]                       rdata;
   } pmd_state_s;

   pmd_state_s state_ff;
   pmd_state_s nxt_state;

   logic             top_mem;
   logic [N_PAIRS-1:0] pair_hit;
   logic [N_PAIRS-1:0] pair_mem;

   pmd_top_cmp u_top (
      .i_system_config_reg   (state_ff.system_config_reg),
      .i_tom_low  (state_ff.tom_low),
      .i_tom_high (state_ff.tom_high),
      .i_addr     (I_REQ.addr),
      .o_to_mem   (top_mem)
   );

   for (genvar g = 0; g < N_PAIRS; g++) begin : g_pair
      pmd_io_range u_rng (
         .i_base   (state_ff.pair[g].base),
         .i_mask   (state_ff.pair[g].mask),
         .i_addr   (I_REQ.addr),
         .i_write  (I_REQ.write),
         .o_hit    (pair_hit[g]),
         .o_to_mem (pair_mem[g])
      );
   end

   function automatic logic [63:0] rd_mux(input pmd_state_s s, input logic [2:0] sel);
      unique case (sel)
         pmd_pkg::SEL_SYSTEM_CONFIG_REG:   rd_mux = s.system_config_reg;
         pmd_pkg::SEL_TOM_LOW:  rd_mux = s.tom_low;
         pmd_pkg::SEL_TOM_HIGH: rd_mux = s.tom_high;
         pmd_pkg::SEL_IO_BASE0: rd_mux = s.pair[0].base;
         pmd_pkg::SEL_IO_MASK0: rd_mux = s.pair[0].mask;
         pmd_pkg::SEL_IO_BASE1: rd_mux = s.pair[1].base;
         pmd_pkg::SEL_IO_MASK1: rd_mux = s.pair[1].mask;
         default:               rd_mux = 64'h0000_0000_0000_0000;
      endcase
   endfunction : rd_mux

   always_comb begin
      logic hit_mem;
      logic any_hit;
      nxt_state = state_ff;
      hit_mem   = 1'b0;
      any_hit   = 1'b0;
      if (I_REG_WE) begin
         unique case (I_REG_SEL)
            pmd_pkg::SEL_SYSTEM_CONFIG_REG:   nxt_state.system_config_reg       = I_REG_WDATA;
            pmd_pkg::SEL_TOM_LOW:  nxt_state.tom_low      = I_REG_WDATA;
            pmd_pkg::SEL_TOM_HIGH: nxt_state.tom_high     = I_REG_WDATA;
            pmd_pkg::SEL_IO_BASE0: nxt_state.pair[0].base = I_REG_WDATA;
            pmd_pkg::SEL_IO_MASK0: nxt_state.pair[0].mask = I_REG_WDATA;
            pmd_pkg::SEL_IO_BASE1: nxt_state.pair[1].base = I_REG_WDATA;
            pmd_pkg::SEL_IO_MASK1: nxt_state.pair[1].mask = I_REG_WDATA;
            default:               nxt_state.system_config_reg       = state_ff.system_config_reg;
         endcase
      end
      nxt_state.rdata = rd_mux(state_ff, I_REG_SEL);
      // Lowest pair wins on overlap; software must avoid that case
      for (int i = N_PAIRS - 1; i >= 0; i--) begin
         if (pair_hit[i]) begin
            any_hit = 1'b1;
            hit_mem = pair_mem[i];
         end
      end
      nxt_state.rsp.valid   = I_REQ.valid;
      nxt_state.rsp.io_hit  = I_REQ.valid && any_hit;
      // Range steering overrides the boundary classification
      nxt_state.rsp.to_mmio = I_REQ.valid && (any_hit ? !hit_mem : !top_mem);
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state_ff <= '0;
      end else if (I_CE) begin
         state_ff <= nxt_state;
      end
   end

   assign O_REG_RDATA    = state_ff.rdata;
   assign O_RSP          = state_ff.rsp;
   // Memory-type combination uses the steering pair bits downstream
   assign O_MEM_TYPE_SEL = state_ff.rsp.io_hit;

   logic [pmd_pkg::PA_W-1:0] lo_lim;
   logic [pmd_pkg::PA_W-1:0] hi_lim;
   logic                     any_hit_c;
   assign lo_lim    = {state_ff.tom_low[pmd_pkg::TOM_MSB:pmd_pkg::TOM_LSB],
                       {pmd_pkg::TOM_LSB{1'b0}}};
   assign hi_lim    = {state_ff.tom_high[pmd_pkg::TOM_MSB:pmd_pkg::TOM_LSB],
                       {pmd_pkg::TOM_LSB{1'b0}}};
   assign any_hit_c = |pair_hit;

   property p_low_mem;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid && !I_REG_WE && state_ff.system_config_reg[pmd_pkg::LOW_EN_BIT] && !any_hit_c
       && I_REQ.addr < lo_lim)
      |=> !O_RSP.to_mmio;
   endproperty
   a_low_mem: assert property (p_low_mem) else $error("low region not memory");

   property p_high_mem;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid && !any_hit_c && state_ff.system_config_reg[pmd_pkg::HIGH_EN_BIT]
       && I_REQ.addr >= pmd_pkg::FOUR_GB && I_REQ.addr < hi_lim)
      |=> !O_RSP.to_mmio;
   endproperty
   a_high_mem: assert property (p_high_mem) else $error("high region not memory");

   property p_high_io;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid && !any_hit_c && I_REQ.addr >= hi_lim
       && I_REQ.addr >= pmd_pkg::FOUR_GB)
      |=> O_RSP.to_mmio;
   endproperty
   a_high_io: assert property (p_high_io) else $error("above high boundary not I/O");

   property p_low_io;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid && !any_hit_c && I_REQ.addr >= lo_lim
       && I_REQ.addr < pmd_pkg::FOUR_GB)
      |=> O_RSP.to_mmio;
   endproperty
   a_low_io: assert property (p_low_io) else $error("gap below 4GB not I/O");

   property p_low_dis;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid && !any_hit_c && !state_ff.system_config_reg[pmd_pkg::LOW_EN_BIT]
       && I_REQ.addr < pmd_pkg::FOUR_GB)
      |=> O_RSP.to_mmio;
   endproperty
   a_low_dis: assert property (p_low_dis) else $error("disabled low not I/O");

   property p_high_dis;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid && !any_hit_c && !state_ff.system_config_reg[pmd_pkg::HIGH_EN_BIT]
       && I_REQ.addr >= pmd_pkg::FOUR_GB)
      |=> O_RSP.to_mmio;
   endproperty
   a_high_dis: assert property (p_high_dis) else $error("disabled high not I/O");

   property p_pair_wr;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid && I_REQ.write && pair_hit[0] && !pair_hit[1])
      |=> (O_RSP.to_mmio == !$past(state_ff.pair[0].base[pmd_pkg::WR_DRAM_BIT]));
   endproperty
   a_pair_wr: assert property (p_pair_wr) else $error("write steering wrong");

   property p_pair_rd;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid && !I_REQ.write && pair_hit[1] && !pair_hit[0])
      |=> (O_RSP.to_mmio == !$past(state_ff.pair[1].base[pmd_pkg::RD_DRAM_BIT]));
   endproperty
   a_pair_rd: assert property (p_pair_rd) else $error("read steering wrong");

   property p_pair_vld;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid && !state_ff.pair[0].mask[pmd_pkg::PAIR_VLD_BIT]
       && !state_ff.pair[1].mask[pmd_pkg::PAIR_VLD_BIT])
      |=> !O_RSP.io_hit;
   endproperty
   a_pair_vld: assert property (p_pair_vld) else $error("invalid pair hit");

   property p_resp;
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_REQ.valid) |=> O_RSP.valid;
   endproperty
   a_resp: assert property (p_resp) else $error("no answer one cycle later");
endmodule : pmd_decoder
`default_nettype wire

// >>> logic/pmd_io_range.sv
// One I/O range pair hit and steering
`timescale 1ns/1ps
`default_nettype none
module pmd_io_range (
   input  wire logic [63:0]               i_base,
   input  wire logic [63:0]               i_mask,
   input  wire logic [pmd_pkg::PA_W-1:0]  i_addr,
   input  wire logic                      i_write,
   output logic                          o_hit,
   output logic                          o_to_mem
);
   localparam int FW = pmd_pkg::IO_MSB - pmd_pkg::IO_LSB + 1;
   logic [FW-1:0] m;

   always_comb begin
      // Low 12 bits are taken as zero, so they never compare
      m     = i_mask[pmd_pkg::IO_MSB:pmd_pkg::IO_LSB];
      o_hit = i_mask[pmd_pkg::PAIR_VLD_BIT] &&
              ((i_addr[pmd_pkg::IO_MSB:pmd_pkg::IO_LSB] & m) ==
               (i_base[pmd_pkg::IO_MSB:pmd_pkg::IO_LSB] & m));
      o_to_mem = i_write ? i_base[pmd_pkg::WR_DRAM_BIT]
                         : i_base[pmd_pkg::RD_DRAM_BIT];
   end
endmodule : pmd_io_range
`default_nettype wire

// >>> logic/pmd_pkg.sv
// Package for the physical memory / I/O region decoder
package pmd_pkg;
   localparam int PA_W = 52;

   // Register access selector codes on the register port
   localparam logic [2:0] SEL_SYSTEM_CONFIG_REG    = 3'h0;
   localparam logic [2:0] SEL_TOM_LOW   = 3'h1;
   localparam logic [2:0] SEL_TOM_HIGH  = 3'h2;
   localparam logic [2:0] SEL_IO_BASE0  = 3'h3;
   localparam logic [2:0] SEL_IO_MASK0  = 3'h4;
   localparam logic [2:0] SEL_IO_BASE1  = 3'h5;
   localparam logic [2:0] SEL_IO_MASK1  = 3'h6;

   // Field positions
   localparam int LOW_EN_BIT   = 20;
   localparam int HIGH_EN_BIT  = 21;
   localparam int TOM_LSB      = 23;
   localparam int TOM_MSB      = 51;
   localparam int IO_LSB       = 12;
   localparam int IO_MSB       = 51;
   localparam int WR_DRAM_BIT  = 3;
   localparam int RD_DRAM_BIT  = 4;
   localparam int PAIR_VLD_BIT = 11;

   // Reset values
   localparam logic [63:0] RST_REG = 64'h0000_0000_0000_0000;

   // Address of the 4-Gbyte line
   localparam logic [PA_W-1:0] FOUR_GB = 52'h0_0001_0000_0000;

   // Cycles from request to answer
   localparam int LAT_CYC = 1;

   typedef struct packed {
      logic            valid;
      logic            write;
      logic [PA_W-1:0] addr;
   } pmd_req_s;

   typedef struct packed {
      logic valid;
      logic to_mmio;
      logic io_hit;
   } pmd_rsp_s;

   typedef struct packed {
      logic [63:0] base;
      logic [63:0] mask;
   } pmd_pair_s;
endpackage : pmd_pkg

// >>> logic/pmd_top_cmp.sv
// Top-of-memory boundary comparator
`timescale 1ns/1ps
`default_nettype none
module pmd_top_cmp (
   input  wire logic [63:0]               i_system_config_reg,
   input  wire logic [63:0]               i_tom_low,
   input  wire logic [63:0]               i_tom_high,
   input  wire logic [pmd_pkg::PA_W-1:0]  i_addr,
   output logic                          o_to_mem
);
   logic [pmd_pkg::PA_W-1:0] low_lim;
   logic [pmd_pkg::PA_W-1:0] high_lim;
   logic                     below_4g;

   always_comb begin
      // Only the aligned field takes part; other bits ignored
      low_lim  = '0;
      high_lim = '0;
      low_lim[pmd_pkg::TOM_MSB:pmd_pkg::TOM_LSB]  =
         i_tom_low[pmd_pkg::TOM_MSB:pmd_pkg::TOM_LSB];
      high_lim[pmd_pkg::TOM_MSB:pmd_pkg::TOM_LSB] =
         i_tom_high[pmd_pkg::TOM_MSB:pmd_pkg::TOM_LSB];
      below_4g = i_addr < pmd_pkg::FOUR_GB;
      if (below_4g) begin
         // Disabled boundary falls back to I/O
         o_to_mem = i_system_config_reg[pmd_pkg::LOW_EN_BIT] && (i_addr < low_lim);
      end else begin
         o_to_mem = i_system_config_reg[pmd_pkg::HIGH_EN_BIT] && (i_addr < high_lim);
      end
   end
endmodule : pmd_top_cmp
`default_nettype wire
